/* File: core/azm_pkg.sv */
package azm_pkg;
    localparam logic [6:0] ADDR_ENABLE = 7'h02;
    localparam logic [6:0] ADDR_ZTHR = 7'h3b;
    localparam logic [6:0] ADDR_RAMP = 7'h3f;
    localparam logic [6:0] ADDR_EMRG = 7'h40;
    localparam logic [6:0] ADDR_ZMODE = 7'h41;
    localparam logic [6:0] ADDR_STATUS = 7'h42;
    localparam logic [7:0] ENABLE_RST = 8'h01;
    localparam logic [7:0] ENABLE_ON = 8'h00;
    localparam logic [7:0] ZTHR_RST = 8'h00;
    localparam logic [7:0] RAMP_RST = 8'h33;
    localparam logic [7:0] EMRG_RST = 8'h00;
    localparam logic [7:0] ZMODE_RST = 8'h07;
    localparam int ZM_AND = 2;
    localparam int ZM_EN_R = 1;
    localparam int ZM_EN_L = 0;
    localparam int TH_L_LSB = 4;
    localparam int TH_R_LSB = 0;
    localparam int UP_RATE_LSB = 6;
    localparam int UP_STEP_LSB = 4;
    localparam int DN_RATE_LSB = 2;
    localparam int DN_STEP_LSB = 0;
    localparam int EM_RATE_LSB = 6;
    localparam int EM_STEP_LSB = 4;
    localparam logic [1:0] RATE_DIRECT = 2'h3;
    localparam logic [7:0] STEP_MAX_HALF_DB = 8'h08;
    localparam logic [7:0] VOL_MUTE = 8'hff;
    localparam int ZCNT_W = 19;
    localparam logic [ZCNT_W-1:0] ZF_0 = 19'd1024;
    localparam logic [ZCNT_W-1:0] ZF_1 = 19'd5120;
    localparam logic [ZCNT_W-1:0] ZF_2 = 19'd10240;
    localparam logic [ZCNT_W-1:0] ZF_3 = 19'd25600;
    localparam logic [ZCNT_W-1:0] ZF_4 = 19'd51200;
    localparam logic [ZCNT_W-1:0] ZF_5 = 19'd102400;
    localparam logic [ZCNT_W-1:0] ZF_6 = 19'd256000;
    localparam logic [ZCNT_W-1:0] ZF_7 = 19'd512000;
    localparam logic [3:0] GF_RESERVED_BAND = 4'h8;
    localparam logic [9:0] SYNC_96K_X10 = 10'd960;
    localparam logic [9:0] SYNC_882K_X10 = 10'd882;
    localparam logic [3:0] SW_MULT_8 = 4'h8;
    localparam logic [3:0] SW_MULT_6 = 4'h6;
    localparam logic [3:0] SW_MULT_5 = 4'h5;
    localparam logic [3:0] SW_MULT_4 = 4'h4;
    localparam int ST_ZMUTE = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_CODE_LSB = 2;
    localparam int ST_RSVD = 5;
endpackage : azm_pkg

/* File: core/azm_zero_mute_ramp.sv */
`timescale 1ns/1ps
module azm_zero_mute_ramp #(
    parameter int SAMPLE_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic audioEnabled,
    input wire logic pwrStageGood,
    input wire logic [3:0] gainFreqLevel,
    input wire logic rateFamily441,
    output logic gainHigh,
    output logic [3:0] switchMult,
    output logic gainFreqReserved,
    output logic [9:0] syncRateKhzX10,
    input wire logic frameClk,
    input wire logic [SAMPLE_W-1:0] sampleLeft,
    input wire logic [SAMPLE_W-1:0] sampleRight,
    input wire logic [7:0] volTarget,
    input wire logic clkError,
    input wire logic supplyFail,
    output logic [7:0] volume,
    output logic analogMute
);
    if (SAMPLE_W < 1 || SAMPLE_W > 32) begin : gBadWidth
        $error("SAMPLE_W must be 1 to 32");
    end

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] zthr;
        logic [7:0] ramp;
        logic [7:0] emrg;
        logic [7:0] zmode;
        logic [39:0] cfg;
        logic cfgTog;
        logic [7:0] rdData;
        logic muteS1;
        logic muteS2;
        logic [5:0] pinS1;
        logic [5:0] pinS2;
        logic locked;
        logic [2:0] code;
        logic reserved;
        logic [9:0] syncRate;
    } azm_ref_s;

    typedef struct packed {
        logic [1:0] rstS;
        logic togS1;
        logic togS2;
        logic togS3;
        logic [1:0] errS1;
        logic [1:0] errS2;
        logic [39:0] cfg;
        logic [1:0][azm_pkg::ZCNT_W-1:0] cnt;
        logic [1:0] trig;
        logic mute;
        logic [7:0] vol;
        logic [1:0] div;
    } azm_link_s;

    azm_ref_s r;
    azm_ref_s next_r;
    azm_link_s k;
    azm_link_s next_k;

    function automatic logic [azm_pkg::ZCNT_W-1:0] zeroFrames(input logic [2:0] sel);
        logic [azm_pkg::ZCNT_W-1:0] f;
        unique case (sel)
            3'h0: f = azm_pkg::ZF_0;
            3'h1: f = azm_pkg::ZF_1;
            3'h2: f = azm_pkg::ZF_2;
            3'h3: f = azm_pkg::ZF_3;
            3'h4: f = azm_pkg::ZF_4;
            3'h5: f = azm_pkg::ZF_5;
            3'h6: f = azm_pkg::ZF_6;
            3'h7: f = azm_pkg::ZF_7;
        endcase
        return f;
    endfunction : zeroFrames

    function automatic logic [3:0] switchOf(input logic [1:0] sel);
        logic [3:0] m;
        unique case (sel)
            2'h3: m = azm_pkg::SW_MULT_8;
            2'h2: m = azm_pkg::SW_MULT_6;
            2'h1: m = azm_pkg::SW_MULT_5;
            2'h0: m = azm_pkg::SW_MULT_4;
        endcase
        return m;
    endfunction : switchOf

    // register side
    always_comb begin
        logic pg;
        logic [3:0] lvl;
        pg = r.pinS2[5];
        lvl = r.pinS2[3:0];
        next_r = r;
        next_r.pinS1 = {pwrStageGood, rateFamily441, gainFreqLevel};
        next_r.pinS2 = r.pinS1;
        next_r.muteS1 = k.mute;
        next_r.muteS2 = r.muteS1;
        if (regWrite) begin
            unique case (regAddr)
                azm_pkg::ADDR_ENABLE: next_r.enable = regWrData;
                azm_pkg::ADDR_ZTHR: next_r.zthr = regWrData;
                azm_pkg::ADDR_RAMP: next_r.ramp = regWrData;
                azm_pkg::ADDR_EMRG: next_r.emrg = regWrData;
                azm_pkg::ADDR_ZMODE: next_r.zmode = regWrData;
                default: next_r.enable = r.enable;
            endcase
        end
        next_r.cfg = {next_r.enable, next_r.zthr, next_r.ramp, next_r.emrg, next_r.zmode};
        if (next_r.cfg != r.cfg) begin
            next_r.cfgTog = ~r.cfgTog;
        end
        if (regRead) begin
            unique case (regAddr)
                azm_pkg::ADDR_ENABLE: next_r.rdData = r.enable;
                azm_pkg::ADDR_ZTHR: next_r.rdData = r.zthr;
                azm_pkg::ADDR_RAMP: next_r.rdData = r.ramp;
                azm_pkg::ADDR_EMRG: next_r.rdData = r.emrg;
                azm_pkg::ADDR_ZMODE: next_r.rdData = r.zmode;
                azm_pkg::ADDR_STATUS: begin
                    next_r.rdData = 8'h00;
                    next_r.rdData[azm_pkg::ST_ZMUTE] = r.muteS2;
                    next_r.rdData[azm_pkg::ST_LOCK] = r.locked;
                    next_r.rdData[azm_pkg::ST_CODE_LSB +: 3] = r.code;
                    next_r.rdData[azm_pkg::ST_RSVD] = r.reserved;
                end
                default: next_r.rdData = 8'h00;
            endcase
        end
        if (!pg) begin
            next_r.locked = 1'b0;
        end else if (!r.locked) begin
            next_r.locked = 1'b1;
            next_r.reserved = (lvl >= azm_pkg::GF_RESERVED_BAND);
            next_r.code = lvl[2:0];
        end
        next_r.syncRate = r.pinS2[4] ? azm_pkg::SYNC_882K_X10 : azm_pkg::SYNC_96K_X10;
        if (rst) begin
            next_r = '0;
            next_r.enable = azm_pkg::ENABLE_RST;
            next_r.zthr = azm_pkg::ZTHR_RST;
            next_r.ramp = azm_pkg::RAMP_RST;
            next_r.emrg = azm_pkg::EMRG_RST;
            next_r.zmode = azm_pkg::ZMODE_RST;
            next_r.cfg = {azm_pkg::ENABLE_RST, azm_pkg::ZTHR_RST, azm_pkg::RAMP_RST,
                          azm_pkg::EMRG_RST, azm_pkg::ZMODE_RST};
            next_r.syncRate = azm_pkg::SYNC_96K_X10;
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    assign regRdData = r.rdData;
    assign audioEnabled = (r.enable == azm_pkg::ENABLE_ON);
    assign gainHigh = r.locked && !r.reserved && r.code[2];
    assign switchMult = (r.locked && !r.reserved) ? switchOf(r.code[1:0]) : 4'h0;
    assign gainFreqReserved = r.locked && r.reserved;
    assign syncRateKhzX10 = r.syncRate;

    // frame clock side
    always_comb begin
        logic [7:0] th;
        logic [7:0] rp;
        logic [7:0] em;
        logic [7:0] zm;
        logic [1:0][SAMPLE_W-1:0] smp;
        logic [1:0] en;
        logic [1:0] chTh;
        logic [azm_pkg::ZCNT_W-1:0] lim;
        logic emerg;
        logic goDown;
        logic [7:0] tgt;
        logic [1:0] rate;
        logic [1:0] stepSel;
        logic [7:0] step;
        logic [1:0] divLim;
        rate = 2'h0;
        stepSel = 2'h0;
        {th, rp, em, zm} = k.cfg[31:0];
        smp = {sampleRight, sampleLeft};
        en = {zm[azm_pkg::ZM_EN_R], zm[azm_pkg::ZM_EN_L]};
        chTh = 2'h0;
        lim = '0;
        next_k = k;
        next_k.rstS = {k.rstS[0], rst};
        next_k.togS1 = r.cfgTog;
        next_k.togS2 = k.togS1;
        next_k.togS3 = k.togS2;
        next_k.errS1 = {clkError, supplyFail};
        next_k.errS2 = k.errS1;
        if (k.togS3 != k.togS2) begin
            next_k.cfg = r.cfg;
        end
        for (int i = 0; i < 2; i++) begin
            lim = zeroFrames(i == 0 ? th[azm_pkg::TH_L_LSB +: 3]
                                    : th[azm_pkg::TH_R_LSB +: 3]);
            if (!en[i] || smp[i] != '0) begin
                next_k.cnt[i] = '0;
                next_k.trig[i] = 1'b0;
            end else begin
                if (k.cnt[i] < lim) begin
                    next_k.cnt[i] = k.cnt[i] + 1'b1;
                end
                next_k.trig[i] = (k.cnt[i] + 1'b1 >= lim);
            end
        end
        if (zm[azm_pkg::ZM_AND]) begin
            next_k.mute = (en != 2'h0) && ((next_k.trig | ~en) == 2'h3);
        end else begin
            next_k.mute = (next_k.trig & en) != 2'h0;
        end
        emerg = (k.errS2 != 2'h0);
        tgt = (emerg || k.cfg[39:32] != azm_pkg::ENABLE_ON) ? azm_pkg::VOL_MUTE
                                                            : volTarget;
        goDown = (k.vol < tgt);
        if (emerg) begin
            rate = em[azm_pkg::EM_RATE_LSB +: 2];
            stepSel = em[azm_pkg::EM_STEP_LSB +: 2];
        end else if (goDown) begin
            rate = rp[azm_pkg::DN_RATE_LSB +: 2];
            stepSel = rp[azm_pkg::DN_STEP_LSB +: 2];
        end else begin
            rate = rp[azm_pkg::UP_RATE_LSB +: 2];
            stepSel = rp[azm_pkg::UP_STEP_LSB +: 2];
        end
        step = azm_pkg::STEP_MAX_HALF_DB >> stepSel;
        divLim = 2'((3'd1 << rate) - 3'd1);
        if (k.vol == tgt) begin
            next_k.div = 2'h0;
        end else if (rate == azm_pkg::RATE_DIRECT) begin
            next_k.vol = tgt;
            next_k.div = 2'h0;
        end else if (k.div >= divLim) begin
            next_k.div = 2'h0;
            if (goDown) begin
                next_k.vol = (tgt - k.vol > step) ? k.vol + step : tgt;
            end else begin
                next_k.vol = (k.vol - tgt > step) ? k.vol - step : tgt;
            end
        end else begin
            next_k.div = k.div + 2'h1;
        end
        if (k.rstS[1]) begin
            next_k.cfg = {azm_pkg::ENABLE_RST, azm_pkg::ZTHR_RST, azm_pkg::RAMP_RST,
                          azm_pkg::EMRG_RST, azm_pkg::ZMODE_RST};
            next_k.cnt = '0;
            next_k.trig = 2'h0;
            next_k.mute = 1'b0;
            next_k.vol = azm_pkg::VOL_MUTE;
            next_k.div = 2'h0;
        end
    end

    always_ff @(posedge frameClk) begin
        k <= next_k;
    end

    assign volume = k.vol;
    assign analogMute = k.mute;
endmodule : azm_zero_mute_ramp

/* File: tb/azm_chk.sv */
`timescale 1ns/1ps
module azm_chk #(
    parameter int SAMPLE_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic audioEnabled,
    input wire logic pwrStageGood,
    input wire logic rateFamily441,
    input wire logic gainHigh,
    input wire logic [3:0] switchMult,
    input wire logic gainFreqReserved,
    input wire logic [9:0] syncRateKhzX10,
    input wire logic frameClk,
    input wire logic [SAMPLE_W-1:0] sampleLeft,
    input wire logic [SAMPLE_W-1:0] sampleRight,
    input wire logic clkError,
    input wire logic supplyFail,
    input wire logic [7:0] volume,
    input wire logic analogMute
);
    logic zeroSeen;
    assign zeroSeen = (sampleLeft == '0) || (sampleRight == '0);
    sequence s_held(x);
        x[*8];
    endsequence
    a_nonzero_unmutes: assert property (@(posedge frameClk) disable iff (rst)
        !zeroSeen |=> !analogMute) else $error("mute held after nonzero samples");
    a_mute_cause: assert property (@(posedge frameClk) disable iff (rst)
        $rose(analogMute) |-> $past(zeroSeen)) else $error("mute without zero sample");
    a_idle_rampdown: assert property (@(posedge frameClk) disable iff (rst)
        s_held(!audioEnabled) |=> volume >= $past(volume)) else $error("volume rose idle");
    a_emerg_rampdown: assert property (@(posedge frameClk) disable iff (rst)
        s_held(clkError || supplyFail) |=> volume >= $past(volume))
        else $error("volume rose in emergency");
    a_enable_write: assert property (@(posedge ref_clk) disable iff (rst)
        regWrite && regAddr == azm_pkg::ADDR_ENABLE |=>
        audioEnabled == ($past(regWrData) == 8'h00)) else $error("enable decode wrong");
    a_gain_decode: assert property (@(posedge ref_clk) disable iff (rst)
        gainHigh |-> switchMult != 4'h0 && !gainFreqReserved) else $error("gain decode wrong");
    a_reserved_nomult: assert property (@(posedge ref_clk) disable iff (rst)
        gainFreqReserved |-> switchMult == 4'h0 && !gainHigh) else $error("reserved decode");
    a_code_held: assert property (@(posedge ref_clk) disable iff (rst)
        (pwrStageGood && switchMult != 4'h0)[*4] |=> $stable(switchMult) && $stable(gainHigh))
        else $error("gain code changed while locked");
    a_sync_low: assert property (@(posedge ref_clk) disable iff (rst)
        rateFamily441[*4] |=> syncRateKhzX10 == azm_pkg::SYNC_882K_X10) else $error("sync rate");
    a_sync_high: assert property (@(posedge ref_clk) disable iff (rst)
        !rateFamily441[*4] |=> syncRateKhzX10 == azm_pkg::SYNC_96K_X10) else $error("sync rate");
endmodule : azm_chk
bind azm_zero_mute_ramp azm_chk #(.SAMPLE_W(SAMPLE_W)) azm_chk_inst (.ref_clk(ref_clk),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .audioEnabled(audioEnabled), .pwrStageGood(pwrStageGood), .rateFamily441(rateFamily441),
    .gainHigh(gainHigh), .switchMult(switchMult), .gainFreqReserved(gainFreqReserved),
    .syncRateKhzX10(syncRateKhzX10), .frameClk(frameClk), .sampleLeft(sampleLeft),
    .sampleRight(sampleRight), .clkError(clkError), .supplyFail(supplyFail),
    .volume(volume), .analogMute(analogMute));

/* File: tb/azm_src.sv */
`timescale 1ns/1ps
module azm_src (
    input wire logic zeroL,
    input wire logic zeroR,
    output logic frameClk,
    output logic [31:0] sampleLeft,
    output logic [31:0] sampleRight
);
    logic [30:0] n;
    initial begin
        n = 31'h0;
        sampleLeft = 32'h1;
        sampleRight = 32'h1;
        frameClk = 1'b0;
        forever #15 frameClk = ~frameClk;
    end
    // one sample per frame, nonzero data moves every frame
    always @(negedge frameClk) begin
        n <= n + 31'h1;
        sampleLeft <= zeroL ? 32'h0 : {n, 1'b1};
        sampleRight <= zeroR ? 32'h0 : {~n, 1'b1};
    end
endmodule : azm_src

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, zeroL = 1'b0;
    logic pwrStageGood = 1'b0, rateFamily441 = 1'b0, clkError = 1'b0, supplyFail = 1'b0;
    logic zeroR = 1'b0, frameClk, audioEnabled, gainHigh, gainFreqReserved, analogMute;
    logic [6:0] regAddr = 7'h0;
    logic [7:0] regWrData = 8'h0, volTarget = 8'h0, regRdData, volume, v;
    logic [3:0] gainFreqLevel = 4'h0, switchMult;
    logic [9:0] syncRateKhzX10;
    logic [31:0] sampleLeft, sampleRight;
    logic [3:0] mt [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
    int mismatches = 0, n_compared = 0, cyc = 0;
    azm_src azm_src_inst (.zeroL(zeroL), .zeroR(zeroR), .frameClk(frameClk),
        .sampleLeft(sampleLeft), .sampleRight(sampleRight));
    azm_zero_mute_ramp azm_zero_mute_ramp_inst (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .audioEnabled(audioEnabled), .pwrStageGood(pwrStageGood),
        .gainFreqLevel(gainFreqLevel), .rateFamily441(rateFamily441), .gainHigh(gainHigh),
        .switchMult(switchMult), .gainFreqReserved(gainFreqReserved),
        .syncRateKhzX10(syncRateKhzX10), .frameClk(frameClk), .sampleLeft(sampleLeft),
        .sampleRight(sampleRight), .volTarget(volTarget), .clkError(clkError),
        .supplyFail(supplyFail), .volume(volume), .analogMute(analogMute));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic fr(input int n);
        repeat (n) @(negedge frameClk);
    endtask : fr
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge ref_clk);
        regWrite = 1'b0;
        fr(5);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        chk("regRdData", e, regRdData);
    endtask : rd
    task automatic chg();
        v = volume;
        for (int k = 0; k < 1100 && volume === v; k++) fr(1);
        v = volume;
    endtask : chg
    task automatic settle();
        for (int k = 0; k < 1100 && volume !== volTarget; k++) fr(1);
    endtask : settle
    task automatic ramp(input logic [1:0] c);
        wr(azm_pkg::ADDR_RAMP, {c, c, c, c});
        for (int i = 0; i < 2; i++) begin
            volTarget = i ? 8'hff : 8'h40;
            chg();
            fr(1 << c);
            if (c == 2'h3) chk("volume", volTarget, v);
            else chk("volume", i ? v + (8'h08 >> c) : v - (8'h08 >> c), volume);
            settle();
        end
    endtask : ramp
    task automatic zrun(input logic l, input logic r, input int n, input logic e);
        @(posedge frameClk);
        zeroL <= l;
        zeroR <= r;
        fr(n);
        chk("analogMute", 1'b0, analogMute);
        fr(1);
        chk("analogMute", e, analogMute);
        @(posedge frameClk);
        zeroL <= 1'b0;
        zeroR <= 1'b0;
        fr(2);
        chk("analogMute", 1'b0, analogMute);
    endtask : zrun
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        rd(azm_pkg::ADDR_ZTHR, 8'h00);
        rd(azm_pkg::ADDR_RAMP, 8'h33);
        rd(azm_pkg::ADDR_EMRG, 8'h00);
        rd(azm_pkg::ADDR_ZMODE, 8'h07);
        rd(7'h10, 8'h00);
        fr(10);
        chk("volume", 8'hff, volume);
        volTarget = 8'hff;
        wr(azm_pkg::ADDR_ENABLE, 8'h00);
        chk("audioEnabled", 1'b1, audioEnabled);
        for (int c = 0; c < 4; c++) ramp(c[1:0]);
        for (int i = 0; i < 2; i++) begin
            wr(azm_pkg::ADDR_EMRG, i ? 8'h50 : 8'h00);
            volTarget = 8'h00;
            settle();
            {supplyFail, clkError} = i ? 2'b10 : 2'b01;
            chg();
            fr(i + 1);
            chk("volume", v + (i ? 8'h04 : 8'h08), volume);
            {supplyFail, clkError} = 2'b00;
        end
        zrun(1'b1, 1'b1, 32'h400, 1'b1);
        zrun(1'b1, 1'b0, 32'h400, 1'b0);
        wr(azm_pkg::ADDR_ZMODE, 8'h03);
        zrun(1'b1, 1'b0, 32'h400, 1'b1);
        wr(azm_pkg::ADDR_ZMODE, 8'h02);
        zrun(1'b1, 1'b0, 32'h400, 1'b0);
        wr(azm_pkg::ADDR_ZMODE, 8'h01);
        zrun(1'b0, 1'b1, 32'h400, 1'b0);
        wr(azm_pkg::ADDR_ZMODE, 8'h03);
        wr(azm_pkg::ADDR_ZTHR, 8'h10);
        rd(azm_pkg::ADDR_ZTHR, 8'h10);
        zrun(1'b1, 1'b0, 32'h1400, 1'b1);
        zrun(1'b0, 1'b1, 32'h400, 1'b1);
        for (int c = 0; c < 9; c++) begin
            @(negedge ref_clk);
            pwrStageGood = 1'b0;
            gainFreqLevel = c[3:0];
            repeat (8) @(negedge ref_clk);
            pwrStageGood = 1'b1;
            repeat (8) @(negedge ref_clk);
            gainFreqLevel = c[3] ? 4'h0 : c[3:0] ^ 4'h3;
            repeat (8) @(negedge ref_clk);
            chk("gainHigh", c < 8 && c[2], gainHigh);
            chk("switchMult", c[3] ? 4'h0 : mt[c[1:0]], switchMult);
            chk("gainFreqReserved", c[3], gainFreqReserved);
        end
        rateFamily441 = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("syncRateKhzX10", 10'h372, syncRateKhzX10);
        rateFamily441 = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("syncRateKhzX10", 10'h3c0, syncRateKhzX10);
        complete_run();
    end
endmodule : tb
